/* File: verilog/rosb_pkg.sv */
/*
 * Shared constants for the remappable output select bank: register offsets,
 * field positions, reset values and the pin numbering of the bank.
 * Assumes an APB bus with 32-bit data and byte addresses.
 */
package rosb_pkg;

    // ****************************************************************
    // Bank geometry
    // ****************************************************************
    localparam int ROSB_NUM_REGS = 8;        // Select registers in the bank.
    localparam int ROSB_NUM_PINS = 16;       // Two pins per register.
    localparam int ROSB_FIRST_PIN = 46;      // Pin number of the lowest pin.
    localparam int ROSB_SEL_W = 6;           // Width of one selector field.
    localparam int ROSB_ADDR_W = 12;         // Decoded APB address bits.

    // ****************************************************************
    // Register offsets (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [11:0] ROSB_OFS_PINS_46_47 = 12'h000;
    localparam logic [11:0] ROSB_OFS_PINS_60_61 = 12'h01C;
    localparam logic [11:0] ROSB_OFS_STRIDE = 12'h004;

    // ****************************************************************
    // Field layout inside a select register
    // ****************************************************************
    localparam int ROSB_ODD_LSB = 8;         // Odd pin field, bits 13 to 8.
    localparam int ROSB_EVEN_LSB = 0;        // Even pin field, bits 5 to 0.
    localparam logic [5:0] ROSB_SEL_RESET = 6'h00;
    localparam logic [5:0] ROSB_SEL_NONE = 6'h00;

    // Mask of the bits that exist in a select register.
    localparam logic [31:0] ROSB_IMPL_MASK = 32'h0000_3F3F;

    // Packed set of selectors, one per pin, pin 46 at index 0.
    typedef logic [15:0][5:0] rosb_sel_t;

endpackage

/* File: verilog/rosb_route_if.sv */
/*
 * Carrier between the register bank and the routing matrix.
 * Assumes both ends run on the same clock; the matrix is combinational.
 */
`timescale 1ns/1ps
interface rosb_route_if
    import rosb_pkg::*;
#(
    parameter int NUM_FUNC = 64
);
    rosb_sel_t sel;                     // Selector per pin.
    logic [NUM_FUNC-1:0] periph;        // Peripheral output functions.
    logic [15:0] routed;                // Level chosen for each pin.
    logic [15:0] active;                // High where a function owns the pin.

    // The bank supplies selectors and functions and reads the result.
    modport bank
    (
        output sel,
        output periph,
        input routed,
        input active
    );

    // The matrix turns selectors into pin levels.
    modport matrix
    (
        input sel,
        input periph,
        output routed,
        output active
    );
endinterface

/* File: verilog/rosb_route.sv */
/*
 * Routing matrix: one multiplexer per remappable pin.
 * Assumes function code 0 means no function and that codes at or above
 * NUM_FUNC are unused and route nothing.
 */
`timescale 1ns/1ps
module rosb_route
    import rosb_pkg::*;
#(
    parameter int NUM_FUNC = 64
)
(
    rosb_route_if.matrix rt
);

    // ****************************************************************
    // Per-pin multiplexers
    // ****************************************************************
    genvar gp;
    generate
        for (gp = 0; gp < ROSB_NUM_PINS; gp = gp + 1)
        begin : g_pin
            // A zero code leaves the pin to its port logic; a code past the
            // last function is treated the same so no x leaks to the pad.
            always_comb
            begin
                if (rt.sel[gp] == ROSB_SEL_NONE || int'(rt.sel[gp]) >= NUM_FUNC)
                begin
                    rt.routed[gp] = 1'b0;
                    rt.active[gp] = 1'b0;
                end
                else
                begin
                    rt.routed[gp] = rt.periph[rt.sel[gp]];
                    rt.active[gp] = 1'b1;
                end
            end
        end
    endgenerate

endmodule

/* File: verilog/rosb_bank.sv */
/*
 * Remappable output select bank: eight APB select registers that pick the
 * peripheral output function driving each of sixteen pins, 46 to 61.
 * Assumes an APB master on pclk and peripheral outputs on the same clock.
 */
// Overview of operation
// RULE_01: Bits 13:8 select the odd pin's function.
// RULE_02: Bits 5:0 select the even pin's function.
// RULE_03: Bits 15:14 read zero, writes ignored.
// RULE_04: Bits 7:6 read zero, writes ignored.
// RULE_05: Selectors are read/write and reset to zero.
// RULE_06: Registers cover pins 46..61 in ascending pairs.
// RULE_07: Code zero routes nothing; others route function.
`timescale 1ns/1ps
module rosb_bank
    import rosb_pkg::*;
#(
    parameter int NUM_FUNC = 64
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_FUNC-1:0] periph_out,
    output logic [15:0] remap_pin_out,
    output logic [15:0] remap_pin_en
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // A six-bit code cannot name more than 64 functions, and code 0 is
    // reserved, so at least two are needed for anything to be routable.
    if (NUM_FUNC < 2 || NUM_FUNC > 64)
    begin : g_bad_num_func
        $error("NUM_FUNC must lie between 2 and 64");
    end

    // Two pins share each register; if the package geometry ever drifts
    // the pair indexing would run past the selector array.
    if (ROSB_NUM_PINS != 2 * ROSB_NUM_REGS)
    begin : g_bad_geometry
        $error("pin count must be twice the register count");
    end

    // Limitation: routing is registered, so a pin follows a new selector
    // or a peripheral edge one clock late. That lag buys pad drivers that
    // come straight from flops and never glitch while a selector changes.
    // Codes at or above NUM_FUNC act as code zero, so a stale or wrong
    // code can never leave an unknown level on a pad.

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        rosb_sel_t sel;          // Selector per pin, pin 46 at index 0.
        logic [31:0] rdata;      // Read data for the current transfer.
        logic ready;             // Access phase may complete.
        logic err;               // Current transfer hit no register.
        logic [15:0] pin_out;    // Registered pin levels.
        logic [15:0] pin_en;     // Registered pin ownership.
    } rosb_state_t;

    rosb_state_t state_reg;      // Current state.
    rosb_state_t state_next;     // Next state.

    // Carrier between the registers and the routing matrix.
    rosb_route_if #(.NUM_FUNC(NUM_FUNC)) route ();

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Returns the register index, or ROSB_NUM_REGS when nothing matches.
    function automatic logic [3:0] reg_index(input logic [31:0] addr);
        logic [3:0] idx;
        idx = 4'(ROSB_NUM_REGS);
        if (addr[31:ROSB_ADDR_W] == '0 && addr[1:0] == 2'b00
            && addr[11:0] >= ROSB_OFS_PINS_46_47
            && addr[11:0] <= ROSB_OFS_PINS_60_61)
        begin
            idx = 4'((addr[11:0] - ROSB_OFS_PINS_46_47) >> 2);
        end
        return idx;
    endfunction

    // Builds the read word of one register; absent bits stay zero.
    function automatic logic [31:0] reg_word(input rosb_sel_t s, input logic [3:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[ROSB_EVEN_LSB +: ROSB_SEL_W] = s[2 * idx];          // RULE_02
        w[ROSB_ODD_LSB +: ROSB_SEL_W] = s[2 * idx + 1];       // RULE_01
        return w & ROSB_IMPL_MASK;                            // RULE_03 RULE_04
    endfunction

    logic [3:0] cur_idx;         // Index decoded from the current address.
    logic cur_hit;               // The address names a register.
    logic access_done;           // Access phase completes at this edge.

    assign cur_idx = reg_index(paddr);
    assign cur_hit = (cur_idx < 4'(ROSB_NUM_REGS));
    assign access_done = psel && penable && state_reg.ready;

    // The matrix sees the live selectors and the live function outputs.
    assign route.sel = state_reg.sel;
    assign route.periph = periph_out;

    rosb_route #(.NUM_FUNC(NUM_FUNC)) u_route
    (
        .rt(route)
    );

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // The setup cycle latches read data and the error flag, so the access
    // phase finishes with no wait state and every bus output is a flop.
    always_comb
    begin
        state_next = state_reg;
        state_next.pin_out = route.routed;                    // RULE_07
        state_next.pin_en = route.active;                     // RULE_07
        if (psel && !penable)
        begin
            state_next.ready = 1'b1;
            state_next.err = !cur_hit;
            if (cur_hit && !pwrite)
            begin
                state_next.rdata = reg_word(state_reg.sel, cur_idx);  // RULE_06
            end
            else
            begin
                state_next.rdata = 32'h0000_0000;
            end
        end
        else if (access_done)
        begin
            // The transfer ends here; drop the answer until the next setup.
            state_next.ready = 1'b0;
            state_next.err = 1'b0;
            state_next.rdata = 32'h0000_0000;
            if (pwrite && cur_hit)
            begin
                // Lane 0 holds the even field, lane 1 the odd field; the
                // two top bits of each lane are not stored.
                if (pstrb[0])
                begin
                    state_next.sel[2 * cur_idx] = pwdata[ROSB_EVEN_LSB +: ROSB_SEL_W]; // RULE_02 RULE_04
                end
                if (pstrb[1])
                begin
                    state_next.sel[2 * cur_idx + 1] = pwdata[ROSB_ODD_LSB +: ROSB_SEL_W]; // RULE_01 RULE_03
                end
            end
        end
        else
        begin
            // Idle bus or a stray access: no answer is pending.
            state_next.ready = 1'b0;
            state_next.err = 1'b0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Every selector clears on reset, so all pins start unrouted.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;                                  // RULE_05
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Every bus and pin output comes straight from the state register.
    assign prdata = state_reg.rdata;
    assign pready = state_reg.ready;
    assign pslverr = state_reg.err;
    assign remap_pin_out = state_reg.pin_out;
    assign remap_pin_en = state_reg.pin_en;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Absent bits of a register always read zero.
    chk_unused_read_zero: assert property ( // RULE_03
        access_done |-> (prdata & ~ROSB_IMPL_MASK) == 32'h0000_0000)
        else $error("unimplemented bits read nonzero");

    chk_gap_bits_zero: assert property ( // RULE_04
        access_done && !pwrite |-> prdata[7:6] == 2'b00)
        else $error("bits 7:6 read nonzero");

    // A written odd field is held in its selector from the next cycle on.
    chk_odd_field_write: assert property ( // RULE_01
        access_done && pwrite && cur_hit && pstrb[1]
        |=> state_reg.sel[2 * $past(cur_idx) + 1] == $past(pwdata[13:8]))
        else $error("odd pin field not written");

    chk_even_field_write: assert property ( // RULE_02
        access_done && pwrite && cur_hit && pstrb[0]
        |=> state_reg.sel[2 * $past(cur_idx)] == $past(pwdata[5:0]))
        else $error("even pin field not written");

    // Reset leaves every selector and every pin enable at zero.
    chk_reset_clear: assert property ( // RULE_05
        $rose(presetn) |-> state_reg.sel == '0 ##1 remap_pin_en == 16'h0000)
        else $error("selectors not cleared by reset");

    // A read returns the pair of the register that was addressed.
    chk_read_pair: assert property ( // RULE_06
        psel && !penable && !pwrite && cur_hit ##1 access_done
        |-> prdata[5:0] == state_reg.sel[2 * $past(cur_idx)]
            && prdata[13:8] == state_reg.sel[2 * $past(cur_idx) + 1])
        else $error("read returned wrong pin pair");

    // Pin 46 follows its selector one cycle later.
    chk_pin_route: assert property ( // RULE_07
        ##1 remap_pin_en[0] == ($past(state_reg.sel[0]) != ROSB_SEL_NONE
            && int'($past(state_reg.sel[0])) < NUM_FUNC)
        && (remap_pin_en[0] || remap_pin_out[0] == 1'b0))
        else $error("pin 46 routing mismatch");

    // Setup is always answered in the very next cycle.
    chk_ready_timing: assert property (
        psel && !penable |=> pready)
        else $error("no answer after setup");

    // The slave never answers unless a setup cycle came just before.
    chk_ready_needs_setup: assert property (
        pready |-> $past(psel && !penable))
        else $error("answer without a setup cycle");

    // The answer stands for the access cycle only, then the bus clears.
    chk_answer_one_cycle: assert property (
        access_done |=> !pready && !pslverr && prdata == 32'h0000_0000)
        else $error("bus answer held past the access cycle");

    // A write carries no read data back.
    chk_write_no_rdata: assert property (
        access_done && pwrite |-> prdata == 32'h0000_0000)
        else $error("read data driven during a write");

    // ****************************************************************
    // Refusal checks
    // ****************************************************************
    // A mapped, aligned word is always answered without an error.
    chk_mapped_no_error: assert property (
        psel && !penable && cur_hit |=> pready && !pslverr)
        else $error("mapped address answered with error");

    // An address outside the bank is refused and reads as zero.
    chk_unmapped_error: assert property (
        psel && !penable && !cur_hit |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped address not refused");

    // A refused write leaves every selector as it was.
    chk_refused_write: assert property (
        access_done && pwrite && !cur_hit |=> state_reg.sel == $past(state_reg.sel))
        else $error("refused write changed a selector");

    // With both field strobes low a write keeps the addressed pair.
    chk_strobe_off_hold: assert property (
        access_done && pwrite && cur_hit && pstrb[1:0] == 2'b00
        |=> state_reg.sel[2 * $past(cur_idx)] == $past(state_reg.sel[2 * cur_idx])
            && state_reg.sel[2 * $past(cur_idx) + 1]
            == $past(state_reg.sel[2 * cur_idx + 1]))
        else $error("write with strobes low changed a field");

    // ****************************************************************
    // Pin checks
    // ****************************************************************
    // Pin 46 shows its chosen function's level one cycle later, else zero.
    chk_pin_low_level: assert property ( // RULE_07
        ##1 remap_pin_out[0] == (remap_pin_en[0] && $past(periph_out[state_reg.sel[0]])))
        else $error("pin 46 level mismatch");

    // Pin 61, the odd pin of the last register, is owned by a live code.
    chk_pin_top_owner: assert property ( // RULE_06
        ##1 remap_pin_en[15] == ($past(state_reg.sel[15]) != ROSB_SEL_NONE
            && int'($past(state_reg.sel[15])) < NUM_FUNC))
        else $error("pin 61 ownership mismatch");

    // Pin 61 shows its chosen function's level one cycle later, else zero.
    chk_pin_top_level: assert property ( // RULE_07
        ##1 remap_pin_out[15] == (remap_pin_en[15] && $past(periph_out[state_reg.sel[15]])))
        else $error("pin 61 level mismatch");

endmodule

/* File: dv/rosb_tb.sv */
/*
 * Self-checking bench for the remappable output select bank.
 * Assumes the bank answers APB with one wait-free access cycle and that
 * pin outputs follow selector or function changes one clock later.
 */
`timescale 1ns/1ps
module tb;
    import rosb_pkg::*;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic pclk = 1'b0; // Bus clock, 100 ns period.
    logic presetn = 1'b0; // Held low for the first 8 cycles.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [63:0] periph_out = 64'h0000_0000_0000_0000; // Function 0 is never routed.
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] remap_pin_out;
    logic [15:0] remap_pin_en;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    rosb_bank #(.NUM_FUNC(64)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_out(periph_out),
        .remap_pin_out(remap_pin_out), .remap_pin_en(remap_pin_en));
    always #50 pclk = ~pclk;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compares one value; an unknown never counts as a match.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20)
            check(32'h0000_0000, 32'h0000_0001); // A bus hang is a mismatch.
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Byte address of select register r, pins 46+2r and 47+2r.
    function automatic logic [31:0] reg_addr(input int r);
        return {20'h0_0000, ROSB_OFS_PINS_46_47 + 12'(r) * ROSB_OFS_STRIDE};
    endfunction
    // Lets the one-clock pin lag pass; reads at the edge see the settled level.
    task automatic settle();
        repeat (3) @(posedge pclk);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Every register reads zero after reset and no pin is owned.
    task automatic test_reset();
        logic [31:0] rd;
        logic err;
        periph_out <= 64'hFFFF_FFFF_FFFF_FFFE;
        for (int r = 0; r < 8; r++)
        begin
            apb(1'b0, reg_addr(r), 32'h0000_0000, 4'h0, rd, err);
            check(rd, 32'h0000_0000);
            check({31'h0000_0000, err}, 32'h0000_0000);
        end
        settle();
        check({16'h0000, remap_pin_en}, 32'h0000_0000);
        check({16'h0000, remap_pin_out}, 32'h0000_0000);
        $display("test_reset done");
    endtask
    // Pin 46+i gets code i+1; the unimplemented bits are written as ones.
    task automatic test_fields();
        logic [31:0] rd;
        logic err;
        logic [5:0] ev;
        logic [5:0] od;
        for (int r = 0; r < 8; r++)
        begin
            ev = 6'(2 * r + 1);
            od = 6'(2 * r + 2);
            apb(1'b1, reg_addr(r), {16'hFFFF, 2'b11, od, 2'b11, ev}, 4'hF, rd, err);
        end
        for (int r = 0; r < 8; r++)
        begin
            ev = 6'(2 * r + 1);
            od = 6'(2 * r + 2);
            apb(1'b0, reg_addr(r), 32'h0000_0000, 4'h0, rd, err);
            check(rd & 32'h0000_003F, {26'h000_0000, ev});
            check(rd & 32'h0000_3F00, {18'h0_0000, od, 8'h00});
            check(rd & 32'hFFFF_C000, 32'h0000_0000);
            check(rd & 32'h0000_00C0, 32'h0000_0000);
            check(rd, {18'h0_0000, od, 2'b00, ev});
        end
        $display("test_fields done");
    endtask
    // Pins follow the coded function, for a pattern and its inverse.
    task automatic test_route();
        logic [63:0] pat;
        pat = 64'h0123_4567_89AB_CDEF;
        for (int k = 0; k < 2; k++)
        begin
            periph_out <= pat;
            settle();
            check({16'h0000, remap_pin_en}, 32'h0000_FFFF);
            check({16'h0000, remap_pin_out}, {16'h0000, pat[16:1]});
            pat = ~pat;
        end
        $display("test_route done");
    endtask
    // Strobes gate fields, an unmapped word is refused, reset clears register 7 and the pin enables.
    task automatic test_refuse();
        logic [31:0] rd;
        logic err;
        apb(1'b1, reg_addr(0), 32'h0000_3F3F, 4'h1, rd, err);
        apb(1'b0, reg_addr(0), 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_023F);
        apb(1'b1, reg_addr(0), 32'h0000_0500, 4'h2, rd, err);
        apb(1'b1, reg_addr(0), 32'h0000_0000, 4'h0, rd, err);
        apb(1'b0, reg_addr(0), 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_053F);
        // Pin 46 carries code 63 and pin 49 code 4; only those two go high.
        periph_out <= 64'h8000_0000_0000_0010;
        settle();
        check({16'h0000, remap_pin_out}, 32'h0000_0009);
        apb(1'b1, 32'h0000_0020, 32'h0000_3F3F, 4'hF, rd, err);
        check({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b0, 32'h0000_0020, 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_0000);
        check({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b1, reg_addr(7) + 32'h0000_0001, 32'h0000_0000, 4'hF, rd, err);
        check({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b1, reg_addr(7) + 32'h0000_1000, 32'h0000_0000, 4'hF, rd, err);
        check({31'h0000_0000, err}, 32'h0000_0001);
        apb(1'b0, reg_addr(7), 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_100F);
        check({31'h0000_0000, err}, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, reg_addr(7), 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_0000);
        settle();
        check({16'h0000, remap_pin_en}, 32'h0000_0000);
        $display("test_refuse done");
    endtask
    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    // The run needs about 130 cycles; 5000 means a hang.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            stop_test();
        end
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_fields();
        test_route();
        test_refuse();
        stop_test();
    end
endmodule
